// ### pmcm_power_manager.v
// What this block does
// R1 - Power-up enters full mode, PLL unbypassed
// R2 - Bypass mode clocks core, system from reference
// R3 - New multiplier applies after lock count expires
// R4 - Bypass mode grants system DMA to L1
// R5 - Sleep gates core clock, keeps PLL, system
// R6 - Sleep wakes on interrupt, bypass bit picks mode
// R7 - Sleep refuses system DMA to L1
// R8 - Deep sleep stops both clocks, disables PLL
// R9 - Deep sleep exits on reset or RTC
// R10 - Regulator voltage in 50 mV steps, disable, bypass
// R11 - Multiplier 1 to 31, resets to 10
// R12 - System divider equals select value 1..15
// R13 - System divider changes without lock wait
// R14 - Core divider 1,2,4,8, changes dynamically
// R15 - Software keeps system clock under its maximum
// R16 - System select zero is ignored
// R17 - Sleep entry by request after transfers finish
`timescale 1ns/100ps
`include "pmcm_regs.vh"

module pmcm_power_manager #(
  parameter [15:0] LOCK_CYCLES = `PMCM_LOCK_COUNT_RESET,
  parameter [11:0] VBASE_MV = `PMCM_VBASE_MV
) (
  input wire clock,
  input wire rst,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire reference_clock_in,
  input wire irqAny,
  input wire rtcWake,
  input wire dmaReq,
  input wire dmaBusy,
  output wire core_clock,
  output wire systemClock,
  output reg pllEnable,
  output reg pllBypass,
  output reg [4:0] pllMultiplier,
  output reg pllLocked,
  output reg l1DmaGrant,
  output reg [1:0] modeOut,
  output reg [11:0] regulatorMv,
  output reg regulatorEnable,
  output reg regulatorBypass
);

  // ****************************************
  // Address decode
  // ****************************************
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_CTRL = 3'h1;
  localparam [2:0] SEL_DIV = 3'h2;
  localparam [2:0] SEL_REG = 3'h3;
  localparam [2:0] SEL_LOCK = 3'h4;
  localparam [2:0] SEL_STAT = 3'h5;

  function [2:0] regSelect;
    input [7:0] addr;
    begin
      if (addr == `PMCM_PLL_CONTROL_OFF) begin
        regSelect = SEL_CTRL;
      end else if (addr == `PMCM_CLOCK_DIV_OFF) begin
        regSelect = SEL_DIV;
      end else if (addr == `PMCM_REGULATOR_CONTROL_OFF) begin
        regSelect = SEL_REG;
      end else if (addr == `PMCM_LOCK_COUNT_OFF) begin
        regSelect = SEL_LOCK;
      end else if (addr == `PMCM_STATUS_OFF) begin
        regSelect = SEL_STAT;
      end else begin
        regSelect = SEL_NONE;
      end
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Bit 0 reference, bit 1 interrupt, bit 2 RTC wake
  wire [2:0] pinRaw;
  reg [2:0] syncA;
  reg [2:0] syncB;

  assign pinRaw = {rtcWake, irqAny, reference_clock_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : gSync
      always @(posedge clock) begin
        if (rst) begin
          syncA[gi] <= 1'b0;
          syncB[gi] <= 1'b0;
        end else begin
          syncA[gi] <= pinRaw[gi];
          syncB[gi] <= syncA[gi];
        end
      end
    end
  endgenerate

  wire refLevel = syncB[0];
  wire irqSeen = syncB[1];
  wire rtcSeen = syncB[2];

  // ****************************************
  // Software registers
  // ****************************************
  reg [4:0] pendingMult;
  reg bypassBit;
  reg pllOffBit;
  reg sleepReq;
  reg deepReq;
  reg [3:0] sysSel;
  reg [1:0] coreSel;
  reg [3:0] vsel;
  reg regDisable;
  reg regBypassBit;
  reg [15:0] lockReload;
  reg [15:0] lockCount;
  reg locking;
  reg [1:0] mode;
  reg [1:0] next_mode;

  wire [2:0] accSel = regSelect(paddr);
  wire wrStrobe = psel & penable & pwrite;
  wire [4:0] wrMult = pwdata[`PMCM_MULT_MSB:`PMCM_MULT_LSB];
  wire [3:0] wrSysSel = pwdata[`PMCM_SYS_SEL_MSB:`PMCM_SYS_SEL_LSB];
  wire enteringLow = (mode != next_mode) &&
                     (next_mode == `PMCM_MODE_SLEEP || next_mode == `PMCM_MODE_DEEP);
  wire leavingDeep = (mode == `PMCM_MODE_DEEP) && (next_mode != `PMCM_MODE_DEEP);

  always @(posedge clock) begin
    if (rst) begin
      pendingMult <= `PMCM_MULT_RESET; // R11
      bypassBit <= 1'b0; // R1
      pllOffBit <= 1'b0;
      sleepReq <= 1'b0;
      deepReq <= 1'b0;
      sysSel <= `PMCM_SYS_SEL_RESET;
      coreSel <= `PMCM_CORE_SEL_RESET;
      vsel <= `PMCM_VSEL_RESET;
      regDisable <= 1'b0;
      regBypassBit <= 1'b0;
      lockReload <= LOCK_CYCLES;
    end else begin
      // Requests drop once the mode is reached
      if (enteringLow) begin
        sleepReq <= 1'b0;
        deepReq <= 1'b0;
      end
      if (wrStrobe && accSel == SEL_CTRL) begin
        // Zero is outside the 1x..31x range and leaves the ratio alone
        if (wrMult != 5'h00) begin
          pendingMult <= wrMult; // R11
        end
        bypassBit <= pwdata[`PMCM_BYPASS_BIT];
        pllOffBit <= pwdata[`PMCM_PLL_OFF_BIT];
        // A fresh write beats the clear of the same cycle
        sleepReq <= pwdata[`PMCM_SLEEP_REQ_BIT]; // R17
        deepReq <= pwdata[`PMCM_DEEP_REQ_BIT]; // R17
      end
      if (wrStrobe && accSel == SEL_DIV) begin
        if (wrSysSel != 4'h0) begin
          sysSel <= wrSysSel; // R12 R13 R16
        end
        coreSel <= pwdata[`PMCM_CORE_SEL_MSB:`PMCM_CORE_SEL_LSB]; // R14
      end
      if (wrStrobe && accSel == SEL_REG) begin
        vsel <= pwdata[`PMCM_VSEL_MSB:`PMCM_VSEL_LSB]; // R10
        regDisable <= pwdata[`PMCM_REG_DISABLE_BIT]; // R10
        regBypassBit <= pwdata[`PMCM_REG_BYPASS_BIT]; // R10
      end
      if (wrStrobe && accSel == SEL_LOCK) begin
        lockReload <= pwdata[`PMCM_LOCK_MSB:`PMCM_LOCK_LSB];
      end
    end
  end

  // ****************************************
  // PLL lock sequencing
  // ****************************************
  // The running ratio stays until the lock count runs out
  wire multChange = wrStrobe && (accSel == SEL_CTRL) && (wrMult != 5'h00);
  wire pllRunning = (mode != `PMCM_MODE_DEEP) && !(mode == `PMCM_MODE_ACTIVE && pllOffBit);

  always @(posedge clock) begin
    if (rst) begin
      lockCount <= 16'h0000;
      locking <= 1'b0;
      pllMultiplier <= `PMCM_MULT_RESET; // R11
      pllLocked <= 1'b1;
    end else if (multChange || leavingDeep) begin
      lockCount <= lockReload; // R3
      locking <= 1'b1;
      pllLocked <= 1'b0;
    end else if (locking && pllRunning) begin
      // A reload of zero still costs one cycle
      if (lockCount <= 16'h0001) begin
        locking <= 1'b0;
        pllLocked <= 1'b1;
        pllMultiplier <= pendingMult; // R3
      end else begin
        lockCount <= lockCount - 16'h0001;
      end
    end
  end

  // ****************************************
  // Mode sequencer
  // ****************************************
  always @* begin
    next_mode = mode;
    case (mode)
      `PMCM_MODE_FULL, `PMCM_MODE_ACTIVE: begin
        // Low-power entry waits for system transfers to drain
        if (deepReq && !dmaBusy) begin
          next_mode = `PMCM_MODE_DEEP; // R17
        end else if (sleepReq && !dmaBusy) begin
          next_mode = `PMCM_MODE_SLEEP; // R17
        end else if (bypassBit) begin
          next_mode = `PMCM_MODE_ACTIVE; // R2
        end else begin
          next_mode = `PMCM_MODE_FULL;
        end
      end
      `PMCM_MODE_SLEEP: begin
        if (irqSeen) begin
          next_mode = bypassBit ? `PMCM_MODE_ACTIVE : `PMCM_MODE_FULL; // R6
        end
      end
      `PMCM_MODE_DEEP: begin
        // Only the RTC or reset brings the part back
        if (rtcSeen) begin
          next_mode = `PMCM_MODE_FULL; // R9
        end
      end
      default: begin
        next_mode = `PMCM_MODE_FULL;
      end
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      mode <= `PMCM_MODE_FULL; // R1 R9
    end else begin
      mode <= next_mode;
    end
  end

  // ****************************************
  // Clock generation
  // ****************************************
  wire coreRun = (mode == `PMCM_MODE_FULL) || (mode == `PMCM_MODE_ACTIVE); // R5 R8
  wire sysRun = (mode != `PMCM_MODE_DEEP); // R5 R8
  wire useRef = (mode == `PMCM_MODE_ACTIVE) || (mode == `PMCM_MODE_SLEEP && bypassBit); // R2
  wire [3:0] coreDiv = 4'h1 << coreSel; // R14

  pmcm_clk_div #(
    .W(4)
  ) uCoreDiv (
    .clock(clock),
    .rst(rst),
    .divisor(coreDiv),
    .run(coreRun),
    .bypass(useRef),
    .refLevel(refLevel),
    .clkOut(core_clock)
  );

  pmcm_clk_div #(
    .W(4)
  ) uSysDiv (
    .clock(clock),
    .rst(rst),
    .divisor(sysSel), // R12 R13
    .run(sysRun),
    .bypass(useRef),
    .refLevel(refLevel),
    .clkOut(systemClock)
  );

  // ****************************************
  // Mode-driven outputs
  // ****************************************
  always @(posedge clock) begin
    if (rst) begin
      pllEnable <= 1'b1; // R1
      pllBypass <= 1'b0; // R1
      l1DmaGrant <= 1'b0;
      modeOut <= `PMCM_MODE_FULL;
      regulatorMv <= VBASE_MV;
      regulatorEnable <= 1'b1;
      regulatorBypass <= 1'b0;
    end else begin
      modeOut <= mode;
      case (mode)
        `PMCM_MODE_FULL: begin
          pllEnable <= 1'b1;
          pllBypass <= 1'b0;
        end
        `PMCM_MODE_ACTIVE: begin
          // Active lets software stop the PLL to save more power
          pllEnable <= ~pllOffBit;
          pllBypass <= 1'b1; // R2
        end
        `PMCM_MODE_SLEEP: begin
          pllEnable <= 1'b1; // R5
          pllBypass <= bypassBit;
        end
        default: begin
          pllEnable <= 1'b0; // R8
          pllBypass <= 1'b1;
        end
      endcase
      // L1 is open to system DMA only while the core is clocked
      l1DmaGrant <= dmaReq && coreRun; // R4 R7 R8
      regulatorMv <= VBASE_MV + {8'h00, vsel} * `PMCM_VSTEP_MV; // R10
      regulatorEnable <= ~regDisable; // R10
      regulatorBypass <= regBypassBit; // R10
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  // Read data is built in the setup cycle so access completes at once
  always @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        pslverr <= (accSel == SEL_NONE);
        if (accSel == SEL_CTRL) begin
          prdata <= {18'h00000, deepReq, sleepReq, 2'h0, pllOffBit, bypassBit, 3'h0, pendingMult};
        end else if (accSel == SEL_DIV) begin
          prdata <= {26'h0000000, coreSel, sysSel};
        end else if (accSel == SEL_REG) begin
          prdata <= {26'h0000000, regBypassBit, regDisable, vsel};
        end else if (accSel == SEL_LOCK) begin
          prdata <= {16'h0000, lockReload};
        end else if (accSel == SEL_STAT) begin
          prdata <= {19'h00000, pllMultiplier, 3'h0, locking, 2'h0, mode};
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

endmodule // pmcm_power_manager

// ### pmcm_regs.vh
`ifndef PMCM_REGS_VH
`define PMCM_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define PMCM_PLL_CONTROL_OFF 8'h00
`define PMCM_CLOCK_DIV_OFF 8'h04
`define PMCM_REGULATOR_CONTROL_OFF 8'h08
`define PMCM_LOCK_COUNT_OFF 8'h0c
`define PMCM_STATUS_OFF 8'h10

// ****************************************
// Field positions
// ****************************************
`define PMCM_MULT_LSB 0
`define PMCM_MULT_MSB 4
`define PMCM_BYPASS_BIT 8
`define PMCM_PLL_OFF_BIT 9
`define PMCM_SLEEP_REQ_BIT 12
`define PMCM_DEEP_REQ_BIT 13
`define PMCM_SYS_SEL_LSB 0
`define PMCM_SYS_SEL_MSB 3
`define PMCM_CORE_SEL_LSB 4
`define PMCM_CORE_SEL_MSB 5
`define PMCM_VSEL_LSB 0
`define PMCM_VSEL_MSB 3
`define PMCM_REG_DISABLE_BIT 4
`define PMCM_REG_BYPASS_BIT 5
`define PMCM_LOCK_LSB 0
`define PMCM_LOCK_MSB 15

// ****************************************
// Reset values and regulator voltage step
// ****************************************
`define PMCM_MULT_RESET 5'h0a
`define PMCM_SYS_SEL_RESET 4'h5
`define PMCM_CORE_SEL_RESET 2'h0
`define PMCM_VSEL_RESET 4'h0
`define PMCM_LOCK_COUNT_RESET 16'h0200
`define PMCM_VSTEP_MV 12'h032
`define PMCM_VBASE_MV 12'h352

// ****************************************
// Operating modes
// ****************************************
`define PMCM_MODE_FULL 2'h0
`define PMCM_MODE_ACTIVE 2'h1
`define PMCM_MODE_SLEEP 2'h2
`define PMCM_MODE_DEEP 2'h3

`endif

// ### pmcm_clk_div.v
`timescale 1ns/100ps

// ****************************************
// Gated clock divider
// ****************************************
module pmcm_clk_div #(
  parameter W = 4
) (
  input wire clock,
  input wire rst,
  input wire [W-1:0] divisor,
  input wire run,
  input wire bypass,
  input wire refLevel,
  output reg clkOut
);

  reg [W-1:0] count;
  reg [W-1:0] activeDiv;

  // New ratio is taken only at a phase boundary or while bypassed, so no runt pulse appears
  always @(posedge clock) begin
    if (rst) begin
      count <= {W{1'b0}};
      activeDiv <= {{(W-1){1'b0}}, 1'b1};
      clkOut <= 1'b0;
    end else if (bypass) begin
      count <= {W{1'b0}};
      if (divisor != {W{1'b0}}) begin
        activeDiv <= divisor;
      end
      // Stopping waits for the low phase of the reference
      clkOut <= run ? refLevel : (clkOut & refLevel);
    end else if (count == activeDiv - {{(W-1){1'b0}}, 1'b1}) begin
      count <= {W{1'b0}};
      if (divisor != {W{1'b0}}) begin
        activeDiv <= divisor;
      end
      // A stop lands on a normal falling edge, never mid-phase
      clkOut <= run ? ~clkOut : 1'b0;
    end else begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // pmcm_clk_div

// ### pmcm_power_manager_props.sv
`timescale 1ns/100ps
// ****************************************
// Port checker for the power manager
// ****************************************
module pmcm_power_manager_props #(
  parameter [15:0] LOCK_CYCLES = 16'h0200,
  parameter [11:0] VBASE_MV = 12'h352
) (
  input wire clock,
  input wire rst,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pready,
  input wire pslverr,
  input wire irqAny,
  input wire rtcWake,
  input wire dmaReq,
  input wire core_clock,
  input wire systemClock,
  input wire pllEnable,
  input wire pllBypass,
  input wire [4:0] pllMultiplier,
  input wire l1DmaGrant,
  input wire [1:0] modeOut,
  input wire [11:0] regulatorMv
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_reset_full; $fell(rst) |-> modeOut == 2'h0 && pllEnable && !pllBypass && pllMultiplier == 5'h0a; endproperty
  a_reset_full: assert property (p_reset_full) else $error("bad state after reset");
  property p_sleep_core; $past(modeOut) == 2'h2 && modeOut == 2'h2 && !$past(core_clock) |-> !core_clock; endproperty
  a_sleep_core: assert property (p_sleep_core) else $error("core clock runs in sleep");
  property p_sleep_dma; $past(modeOut) == 2'h2 && modeOut == 2'h2 |-> !l1DmaGrant; endproperty
  a_sleep_dma: assert property (p_sleep_dma) else $error("grant in sleep");
  property p_active_dma; $past(modeOut) == 2'h1 && modeOut == 2'h1 && $past(dmaReq) |-> l1DmaGrant; endproperty
  a_active_dma: assert property (p_active_dma) else $error("no grant in bypass mode");
  property p_deep_off; $past(modeOut) == 2'h3 && modeOut == 2'h3 && !$past(systemClock) && !$past(core_clock)
    |-> !pllEnable && !systemClock && !core_clock; endproperty
  a_deep_off: assert property (p_deep_off) else $error("clocks or PLL alive in deep sleep");
  property p_deep_hold; modeOut == 2'h3 && !rtcWake && !$past(rtcWake) && !$past(rtcWake, 2) && !$past(rtcWake, 3) |=> modeOut == 2'h3; endproperty
  a_deep_hold: assert property (p_deep_hold) else $error("left deep sleep without wake");
  property p_deep_exit; $past(modeOut) == 2'h3 && modeOut != 2'h3 |-> modeOut == 2'h0; endproperty
  a_deep_exit: assert property (p_deep_exit) else $error("deep sleep exit not to full");
  property p_sleep_hold; modeOut == 2'h2 && !irqAny && !$past(irqAny) && !$past(irqAny, 2) && !$past(irqAny, 3) |=> modeOut == 2'h2; endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("left sleep without interrupt");
  property p_mult_hold; psel && penable && pwrite && paddr == 8'h00 |=> $stable(pllMultiplier) [*2]; endproperty
  a_mult_hold: assert property (p_mult_hold) else $error("multiplier changed before lock");
  property p_apb_ready; psel && !penable |=> pready; endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("no ready in access cycle");
  property p_unmapped; psel && !penable && paddr > 8'h10 |=> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error for unmapped address");
  property p_vstep; regulatorMv >= VBASE_MV && (regulatorMv - VBASE_MV) % 12'h032 == 12'h000; endproperty
  a_vstep: assert property (p_vstep) else $error("voltage off the step grid");
  cover property (modeOut == 2'h1);
  cover property (modeOut == 2'h2);
  cover property (modeOut == 2'h3);
endmodule // pmcm_power_manager_props

bind pmcm_power_manager pmcm_power_manager_props #(.LOCK_CYCLES(LOCK_CYCLES), .VBASE_MV(VBASE_MV)) props_i (
  .clock(clock), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .irqAny(irqAny), .rtcWake(rtcWake), .dmaReq(dmaReq),
  .core_clock(core_clock), .systemClock(systemClock), .pllEnable(pllEnable), .pllBypass(pllBypass),
  .pllMultiplier(pllMultiplier), .l1DmaGrant(l1DmaGrant), .modeOut(modeOut), .regulatorMv(regulatorMv));

// ### test_power_mode_clock_manager.sv
`timescale 1ns/100ps
module test_power_mode_clock_manager;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg [7:0] paddr = 8'h00;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [31:0] pwdata = 32'h0;
  reg refIn = 1'b0;
  reg [1:0] refCnt = 2'h0;
  reg irqAny = 1'b0;
  reg rtcWake = 1'b0;
  reg dmaReq = 1'b0;
  reg dmaBusy = 1'b0;
  reg [31:0] rd;
  reg er;
  reg [4:0] old;
  integer fail_count, tests_run, i;
  integer cycles = 0;
  wire [31:0] prdata;
  wire [4:0] pllMultiplier;
  wire [1:0] modeOut;
  wire [11:0] regulatorMv;
  wire pready, pslverr, core_clock, systemClock, pllEnable, pllBypass, pllLocked, l1DmaGrant;
  wire regulatorEnable, regulatorBypass;
  wire [1:0] clks = {systemClock, core_clock};
  // Small lock count keeps the run short
  pmcm_power_manager #(.LOCK_CYCLES(16'h0004)) pmcm_power_manager_i (
    .clock(clock), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reference_clock_in(refIn),
    .irqAny(irqAny), .rtcWake(rtcWake), .dmaReq(dmaReq), .dmaBusy(dmaBusy), .core_clock(core_clock),
    .systemClock(systemClock), .pllEnable(pllEnable), .pllBypass(pllBypass), .pllMultiplier(pllMultiplier),
    .pllLocked(pllLocked), .l1DmaGrant(l1DmaGrant), .modeOut(modeOut), .regulatorMv(regulatorMv),
    .regulatorEnable(regulatorEnable), .regulatorBypass(regulatorBypass));
  initial forever #50 clock = ~clock;
  // Reference period of six cycles, distinct from every divided rate the sequence selects
  always @(posedge clock) begin
    refCnt <= (refCnt == 2'h2) ? 2'h0 : refCnt + 2'h1;
    if (refCnt == 2'h2) refIn <= ~refIn;
  end
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      conclude;
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clock);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      penable <= 1'b0;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      // Only the bench timeout ends a wait for ready
      while (pready !== 1'b1) begin
        @(posedge clock);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  task waitMode(input [1:0] m);
    integer n;
    begin
      n = 0;
      while (modeOut !== m && n < 60) begin
        @(posedge clock);
        n = n + 1;
      end
      chk({30'h0, modeOut}, {30'h0, m});
    end
  endtask
  // Period of clks[k] in cycles; e of zero means no rising edge at all
  task per(input k, input [31:0] e);
    integer n, c, r;
    reg p;
    begin
      n = 0;
      c = 0;
      r = 0;
      p = clks[k];
      while (r < 3 && n < ((e == 0) ? 40 : 200)) begin
        @(posedge clock);
        n = n + 1;
        c = c + 1;
        if (clks[k] === 1'b1 && p !== 1'b1) begin
          r = r + 1;
          if (r == 3) chk(c, e);
          c = 0;
        end
        p = clks[k];
      end
      if (r < 3) chk((e == 0) ? r : 32'hffffffff, e);
    end
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    fail_count = 0;
    tests_run = 0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdc(8'h10, 32'h00000a00);
    chk({30'h0, pllEnable, pllBypass}, 32'h2);
    rdc(8'h04, 32'h00000005);
    rdc(8'h08, 32'h0);
    rdc(8'h0c, 32'h00000004);
    chk({20'h0, regulatorMv}, 32'h352);
    rdc(8'h20, 32'h0);
    chk({31'h0, er}, 32'h1);
    xfer(1'b1, 8'h24, 32'hffffffff);
    chk({31'h0, er}, 32'h1);
    old = 5'h0a;
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, 8'h00, {27'h0, 20'h0a01f >> (i * 5)} & 32'h1f);
      @(posedge clock);
      chk({27'h0, pllMultiplier}, {27'h0, old});
      chk({31'h0, pllLocked}, (i == 1) ? 32'h1 : 32'h0);
      repeat (10) @(posedge clock);
      old = (20'h0a3ff >> (i * 5)) & 20'h1f;
      chk({27'h0, pllMultiplier}, {27'h0, old});
      chk({31'h0, pllLocked}, 32'h1);
    end
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, 8'h04, ((32'h5f61 >> (i * 4)) & 32'hf) | (i << 4));
      per(1'b1, 2 * ((32'h5f61 >> (i * 4)) & 32'hf));
      per(1'b0, 2 << i);
    end
    xfer(1'b1, 8'h04, 32'h30);
    rdc(8'h04, 32'h35);
    xfer(1'b1, 8'h08, 32'h3f);
    // Step lands one edge, the millivolt output the next
    repeat (2) @(posedge clock);
    chk({18'h0, regulatorMv, regulatorEnable, regulatorBypass}, 32'h1901);
    xfer(1'b1, 8'h00, 32'h10a);
    waitMode(2'h1);
    per(1'b0, 6);
    per(1'b1, 6);
    xfer(1'b1, 8'h00, 32'h30a);
    repeat (2) @(posedge clock);
    chk({30'h0, pllEnable, pllBypass}, 32'h1);
    dmaReq <= 1'b1;
    repeat (3) @(posedge clock);
    chk({31'h0, l1DmaGrant}, 32'h1);
    dmaBusy <= 1'b1;
    xfer(1'b1, 8'h00, 32'h110a);
    repeat (10) @(posedge clock);
    chk({30'h0, modeOut}, 32'h1);
    dmaBusy <= 1'b0;
    waitMode(2'h2);
    repeat (20) @(posedge clock);
    per(1'b0, 0);
    per(1'b1, 6);
    chk({30'h0, pllEnable, l1DmaGrant}, 32'h2);
    irqAny <= 1'b1;
    waitMode(2'h1);
    irqAny <= 1'b0;
    xfer(1'b1, 8'h00, 32'h100a);
    waitMode(2'h2);
    irqAny <= 1'b1;
    waitMode(2'h0);
    irqAny <= 1'b0;
    xfer(1'b1, 8'h00, 32'h200a);
    waitMode(2'h3);
    repeat (20) @(posedge clock);
    chk({31'h0, pllEnable}, 32'h0);
    per(1'b0, 0);
    per(1'b1, 0);
    irqAny <= 1'b1;
    repeat (10) @(posedge clock);
    chk({30'h0, modeOut}, 32'h3);
    irqAny <= 1'b0;
    rtcWake <= 1'b1;
    waitMode(2'h0);
    rtcWake <= 1'b0;
    per(1'b0, 16);
    xfer(1'b1, 8'h00, 32'h200a);
    waitMode(2'h3);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    chk({30'h0, modeOut}, 32'h0);
    conclude;
  end
endmodule // test_power_mode_clock_manager
